// file: verilog/pic_prioritized_interrupt_control.sv
/*
 * pic_prioritized_interrupt_control: request flags, mask, priority, global
 * enable, skip-test flags and sampled edge detection for a small core.
 * Assumes the core sequencer pulses its command fields for one clock and
 * that peripheral event inputs are one-clock pulses on this clock.
 */
`default_nettype none


module pic_prioritized_interrupt_control (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // pins (asynchronous)
    input  wire logic                   nonmaskPinN,
    input  wire logic                   extRiseInput,
    input  wire logic                   extFallInput,
    input  wire logic [3:0]             upperAnalogPins,
    // peripheral event pulses
    input  wire logic                   timerAMatch,
    input  wire logic                   timerBMatch,
    input  wire logic                   evcntMatchA,
    input  wire logic                   evcntMatchB,
    input  wire logic                   countInputFall,
    input  wire logic                   conversionStored,
    input  wire logic                   rxBufferFull,
    input  wire logic                   txBufferEmpty,
    input  wire logic                   evcntOverflow,
    input  wire logic                   rxError,
    input  wire logic                   supplyRise,
    // core sequencer
    input  wire pic_pkg::pic_core_cmd_t cmd,
    output var  pic_pkg::pic_ack_t      ack,
    output logic                        skipResult,
    output logic                        globalEnableFf,
    // register port for the mask
    input  wire logic [0:0]             regAddr,
    input  wire logic [7:0]             regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic [7:0]                  regRdata
);

    // ------------------------------------------------------------------
    // sampling pulse and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] divCnt;
    logic       samplePulse;
    // 7 sampled pins: nonmask, rise, fall, 4 analog
    logic [6:0] pinS1, pinS2, pinS3;
    logic       nmiLevel;

    // divide clock so one sample covers four states
    always_ff @(posedge clk) begin
        if (rst) begin
            divCnt      <= 2'h0;
            samplePulse <= 1'b0;
        end else begin
            divCnt      <= (divCnt == pic_pkg::SAMPLE_DIV_LAST) ? 2'h0 : divCnt + 2'h1;
            samplePulse <= (divCnt == pic_pkg::SAMPLE_DIV_LAST);
        end
    end

    // three-stage capture; stage 1 feeds only stage 2
    always_ff @(posedge clk) begin
        if (rst) begin
            pinS1 <= 7'h7F;
            pinS2 <= 7'h7F;
            pinS3 <= 7'h7F;
        end else begin
            pinS1 <= {upperAnalogPins, extFallInput, ~extRiseInput, nonmaskPinN};
            pinS2 <= pinS1;
            pinS3 <= pinS2;
        end
    end

    // agreed level: changes only once stages two and three match
    logic [6:0] pinStable;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinStable <= 7'h7F;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (pinS2[i] == pinS3[i]) begin
                    pinStable[i] <= pinS3[i];
                end
            end
        end
    end
    assign nmiLevel = pinStable[0];

    // ------------------------------------------------------------------
    // qualified edge detection (all active-low after inversion)
    // ------------------------------------------------------------------
    // six lanes: rise input (inverted), fall input, four analog pins.
    // a lane fires after three successive low samples and re-arms only after
    // a high sample, so a held level yields one edge and short noise none.
    logic [5:0] edgeHit;
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_lane
            logic [1:0] lowRun;
            logic       armed;
            always_ff @(posedge clk) begin
                if (rst) begin
                    lowRun <= 2'h0;
                    armed  <= 1'b0;
                    edgeHit[g] <= 1'b0;
                end else begin
                    edgeHit[g] <= 1'b0;
                    if (samplePulse) begin
                        if (pinStable[g + 1]) begin
                            lowRun <= 2'h0;
                            armed  <= 1'b1;
                        end else if (armed) begin
                            if (lowRun == 2'(pic_pkg::QUALIFY_SAMPLES - 1)) begin
                                edgeHit[g] <= 1'b1;
                                armed      <= 1'b0;
                                lowRun     <= 2'h0;
                            end else begin
                                lowRun <= lowRun + 2'h1;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // nonmaskable: filtered pulse from outside, falling edge sets the flag
    logic nmiPrev;
    always_ff @(posedge clk) begin
        if (rst) begin
            nmiPrev <= 1'b1;
        end else begin
            nmiPrev <= nmiLevel;
        end
    end
    logic nmiFall;
    assign nmiFall = nmiPrev & ~nmiLevel;

    // ------------------------------------------------------------------
    // priority and acknowledge decision
    // ------------------------------------------------------------------
    logic [9:0] reqFlag;
    logic [9:0] maskBits;
    logic       nmiFlag;
    logic [7:0] testFlag;
    pic_pkg::pic_ack_state_t ackState;
    logic [3:0] ackCnt;

    // vector for the group index of a flag pair
    function automatic logic [15:0] group_vector(input logic [2:0] grp);
        case (grp)
            3'h0:    group_vector = pic_pkg::VEC_TIMER;
            3'h1:    group_vector = pic_pkg::VEC_EXT;
            3'h2:    group_vector = pic_pkg::VEC_EVCNT;
            3'h3:    group_vector = pic_pkg::VEC_CNTADC;
            default: group_vector = pic_pkg::VEC_SERIAL;
        endcase
    endfunction : group_vector

    logic [9:0] live;
    logic       takeNmi, takeMask, takeTrap;
    logic [2:0] winGrp;
    logic [9:0] ackClear;
    always_comb begin
        live     = reqFlag & ~maskBits & {10{globalEnableFf}};
        takeNmi  = cmd.instrEnd && (ackState == pic_pkg::PIC_IDLE) && nmiFlag;
        takeTrap = cmd.softwareTrapInstr && (ackState == pic_pkg::PIC_IDLE) && !takeNmi;
        takeMask = 1'b0;
        winGrp   = 3'h0;
        ackClear = 10'h000;
        // lowest group number wins
        for (int k = 4; k >= 0; k--) begin
            if (live[2*k] | live[2*k+1]) begin
                takeMask = 1'b1;
                winGrp   = 3'(k);
            end
        end
        takeMask = takeMask && cmd.instrEnd && (ackState == pic_pkg::PIC_IDLE)
                   && !takeNmi && !takeTrap;
        if (takeMask) begin
            // both of a pair unmasked: keep both for software to sort out
            // one of the pair masked: clear only the unmasked flag, the masked one stays pending
            if (!(~maskBits[2*winGrp] & ~maskBits[2*winGrp+1])) begin
                ackClear[2*winGrp]   = ~maskBits[2*winGrp];
                ackClear[2*winGrp+1] = ~maskBits[2*winGrp+1];
            end
        end
    end

    // ------------------------------------------------------------------
    // skip-test decode
    // ------------------------------------------------------------------
    logic [17:0] testVec;
    logic [9:0]  skipClrReq;
    logic [7:0]  skipClrTest;
    always_comb begin
        testVec     = {testFlag[7:1], nmiLevel, reqFlag};
        skipClrReq  = 10'h000;
        skipClrTest = 8'h00;
        if (cmd.skipTest && cmd.skipSel <= pic_pkg::SEL_LAST) begin
            if (cmd.skipSel < pic_pkg::SEL_TEST_BASE) begin
                skipClrReq[cmd.skipSel[3:0]] = 1'b1;
            end else if (cmd.skipSel != pic_pkg::SEL_TEST_BASE) begin
                skipClrTest[3'(cmd.skipSel - pic_pkg::SEL_TEST_BASE)] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            skipResult <= 1'b0;
        end else if (cmd.skipTest) begin
            skipResult <= (cmd.skipSel <= pic_pkg::SEL_LAST) ? testVec[cmd.skipSel] : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // request flags: set beats clear
    // ------------------------------------------------------------------
    logic [9:0] reqSet;
    assign reqSet = {txBufferEmpty, rxBufferFull,
                     conversionStored, countInputFall,
                     evcntMatchB, evcntMatchA,
                     edgeHit[1], edgeHit[0],
                     timerBMatch, timerAMatch};

    // mask never touches the flags, only acknowledge and test do
    always_ff @(posedge clk) begin
        if (rst) begin
            reqFlag <= 10'h000;
        end else begin
            reqFlag <= (reqFlag & ~(ackClear | skipClrReq)) | reqSet;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nmiFlag <= 1'b0;
        end else if (nmiFall) begin
            nmiFlag <= 1'b1;
        end else if (takeNmi) begin
            nmiFlag <= 1'b0;
        end
    end

    // test flags: bit 0 unused (pin level read live); none feed the priority
    logic [7:0] testSet;
    assign testSet = {edgeHit[5:2], supplyRise, rxError, evcntOverflow, 1'b0};
    always_ff @(posedge clk) begin
        if (rst) begin
            testFlag <= 8'h00;
        end else begin
            testFlag <= (testFlag & ~skipClrTest) | testSet;
        end
    end

    // ------------------------------------------------------------------
    // mask register and global enable
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || cmd.stopMode) begin
            maskBits <= pic_pkg::MASK_RESET;
        end else if (cmd.maskWrite && cmd.maskBit < 4'(pic_pkg::NUM_MASKABLE)) begin
            maskBits[cmd.maskBit] <= cmd.maskValue;
        end else if (regWrite) begin
            if (regAddr == 1'b0) begin
                maskBits[7:0] <= regWdata;
            end else begin
                maskBits[9:8] <= regWdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= (regAddr == 1'b0) ? maskBits[7:0] : {6'h00, maskBits[9:8]};
        end
    end

    // clear wins over enable in the same cycle
    always_ff @(posedge clk) begin
        if (rst || cmd.stopMode || cmd.disableInstr || takeNmi || takeMask || takeTrap) begin
            globalEnableFf <= 1'b0;
        end else if (cmd.enableInstr) begin
            globalEnableFf <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // acknowledge sequence: 16 states, three pushes then vector
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ackState <= pic_pkg::PIC_IDLE;
            ackCnt   <= 4'h0;
            ack      <= '0;
        end else begin
            ack.vectorValid <= 1'b0;
            case (ackState)
                pic_pkg::PIC_IDLE: begin
                    if (takeNmi || takeTrap || takeMask) begin
                        ackState   <= pic_pkg::PIC_PUSH_PSW;
                        ackCnt     <= 4'h0;
                        ack.busy   <= 1'b1;
                        ack.pushStep <= 2'h1;
                        ack.vector <= takeNmi  ? pic_pkg::VEC_NONMASK :
                                      takeTrap ? pic_pkg::VEC_SOFTTRAP :
                                                 group_vector(winGrp);
                    end
                end
                default: begin
                    ackCnt <= ackCnt + 4'h1;
                    if (ackCnt == 4'h3) begin
                        ackState     <= pic_pkg::PIC_PUSH_PCH;
                        ack.pushStep <= 2'h2;
                    end else if (ackCnt == 4'h7) begin
                        ackState     <= pic_pkg::PIC_PUSH_PCL;
                        ack.pushStep <= 2'h3;
                    end else if (ackCnt == pic_pkg::ACK_LAST - 4'h1) begin
                        ackState        <= pic_pkg::PIC_IDLE;
                        ack.busy        <= 1'b0;
                        ack.pushStep    <= 2'h0;
                        ack.vectorValid <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_start;
        !ack.busy ##1 ack.busy;
    endsequence
    property p_ack_len;
        @(posedge clk) disable iff (rst) s_start |-> ack.busy [*8] ##8 ack.vectorValid;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("acknowledge not 16 states");

    property p_nmi_vec;
        @(posedge clk) disable iff (rst) takeNmi |=> ack.vector == pic_pkg::VEC_NONMASK;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("wrong nonmask vector");

    property p_ie_clear;
        @(posedge clk) disable iff (rst) (takeNmi || takeMask) |=> !globalEnableFf;
    endproperty
    a_ie_clear: assert property (p_ie_clear) else $error("enable kept on acknowledge");

    property p_nmi_any;
        @(posedge clk) disable iff (rst)
            (nmiFlag && cmd.instrEnd && ackState == pic_pkg::PIC_IDLE) |-> takeNmi;
    endproperty
    a_nmi_any: assert property (p_nmi_any) else $error("nonmask refused");

    property p_mask_gate;
        @(posedge clk) disable iff (rst) takeMask |-> globalEnableFf
            && ((reqFlag[2*winGrp] && !maskBits[2*winGrp])
            || (reqFlag[2*winGrp+1] && !maskBits[2*winGrp+1]));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked request taken");

    property p_stop_mask;
        @(posedge clk) disable iff (rst) cmd.stopMode |=> maskBits == pic_pkg::MASK_RESET;
    endproperty
    a_stop_mask: assert property (p_stop_mask) else $error("stop left mask open");

    property p_pair_keep;
        @(posedge clk) disable iff (rst)
            (takeMask && !maskBits[2*winGrp] && !maskBits[2*winGrp+1]
             && reqFlag[2*winGrp] && !skipClrReq[2*winGrp]) |=> reqFlag[2*$past(winGrp)];
    endproperty
    a_pair_keep: assert property (p_pair_keep) else $error("pair flag lost");

    property p_skip_clear;
        @(posedge clk) disable iff (rst)
            (cmd.skipTest && cmd.skipSel == 5'h0B && !evcntOverflow) |=> !testFlag[pic_pkg::TF_OVF];
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("test flag not cleared");

endmodule : pic_prioritized_interrupt_control

`default_nettype wire

// file: verilog/pic_pkg.sv
/*
 * pic_pkg: constants and carrier types for the prioritised interrupt control.
 * Assumes one system clock; a "state" is one clock period of that clock.
 */
`default_nettype none

package pic_pkg;

    // ------------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------------
    localparam logic [15:0] VEC_NONMASK  = 16'h0004;
    localparam logic [15:0] VEC_TIMER    = 16'h0008;
    localparam logic [15:0] VEC_EXT      = 16'h0010;
    localparam logic [15:0] VEC_EVCNT    = 16'h0018;
    localparam logic [15:0] VEC_CNTADC   = 16'h0020;
    localparam logic [15:0] VEC_SERIAL   = 16'h0028;
    localparam logic [15:0] VEC_SOFTTRAP = 16'h0060;

    // ------------------------------------------------------------------
    // request flag / mask bit positions (mask bit i guards flag i)
    // ------------------------------------------------------------------
    localparam int REQ_TIMER_A = 0;
    localparam int REQ_TIMER_B = 1;
    localparam int REQ_EXT_RISE = 2;
    localparam int REQ_EXT_FALL = 3;
    localparam int REQ_EV_A    = 4;
    localparam int REQ_EV_B    = 5;
    localparam int REQ_CNT_IN  = 6;
    localparam int REQ_CONV    = 7;
    localparam int REQ_SER_RX  = 8;
    localparam int REQ_SER_TX  = 9;
    localparam int NUM_MASKABLE = 10;

    // ------------------------------------------------------------------
    // test flag positions
    // ------------------------------------------------------------------
    localparam int TF_PIN    = 0;
    localparam int TF_OVF    = 1;
    localparam int TF_RXERR  = 2;
    localparam int TF_SUPPLY = 3;
    localparam int TF_AN4    = 4;
    localparam int NUM_TEST  = 8;

    // skip-test selector: 0..9 request flags, 10..17 test flags
    localparam logic [4:0] SEL_TEST_BASE = 5'h0A;
    localparam logic [4:0] SEL_LAST      = 5'h11;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [9:0] MASK_RESET   = 10'h3FF;
    localparam int SAMPLE_STATES  = 4;    // one sampling period in states
    localparam int QUALIFY_SAMPLES = 3;   // 3 samples = 12 states
    localparam int ACK_STATES     = 16;
    localparam logic [1:0] SAMPLE_DIV_LAST = 2'(SAMPLE_STATES - 1);
    localparam logic [3:0] ACK_LAST        = 4'(ACK_STATES - 1);

    // acknowledge sequence steps
    typedef enum logic [1:0] {
        PIC_IDLE     = 2'b00,
        PIC_PUSH_PSW = 2'b01,
        PIC_PUSH_PCH = 2'b10,
        PIC_PUSH_PCL = 2'b11
    } pic_ack_state_t;

    // core command carrier
    typedef struct packed {
        logic       enableInstr;
        logic       disableInstr;
        logic       stopMode;
        logic       instrEnd;
        logic       softwareTrapInstr;
        logic       maskWrite;
        logic [3:0] maskBit;
        logic       maskValue;
        logic       skipTest;
        logic [4:0] skipSel;
    } pic_core_cmd_t;

    // acknowledge answer carrier
    typedef struct packed {
        logic        busy;
        logic        vectorValid;
        logic [15:0] vector;
        logic [1:0]  pushStep;
    } pic_ack_t;

endpackage : pic_pkg

`default_nettype wire

// file: verification/pic_core_model.sv
/*
 * pic_core_model: core sequencer side; records every acknowledge it sees.
 * Assumes the ack carrier comes from the controller on the same clock.
 */
`default_nettype none

module pic_core_model (
    // clock
    input  wire logic              clk,
    // acknowledge from the controller
    input  wire pic_pkg::pic_ack_t ack,
    // what the sequencer observed
    output logic [15:0]            lastVec,
    output int                     busyLen,
    output logic                   orderOk
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt      = 0;
    initial orderOk = 1'h1;
    // count busy states; status for 4 states, then PC high for 4, then PC low
    always @(posedge clk) begin
        if (ack.busy) begin
            cnt <= cnt + 1;
            if (ack.pushStep != 2'((cnt < 4) ? 1 : (cnt < 8) ? 2 : 3)) orderOk <= 1'h0;
        end
        if (ack.vectorValid) begin
            lastVec <= ack.vector;
            busyLen <= cnt + 1;
            cnt     <= 0;
        end
    end
endmodule : pic_core_model

`default_nettype wire

// file: verification/tb.sv
/*
 * tb: self-checking bench for the prioritised interrupt control.
 * Assumes the 4 ns clock and the core/register timing of the hand-over.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, nmiN = 1'h1, rise = 1'h0, rWr = 1'h0, rRd = 1'h0;
    logic fall = 1'h1;
    logic [3:0] an = 4'hF;
    logic [0:0] rAddr = 1'h0;
    logic [7:0] rWd = 8'h00, rDat, r;
    logic [10:0] ev = 11'h000;
    pic_pkg::pic_core_cmd_t cmd = '0;
    pic_pkg::pic_ack_t ack;
    logic skipResult, ge, bsy, v, orderOk;
    logic [15:0] lastVec;
    int busyLen, err_count = 0, n_tests = 0, mFl = 0, mMk = 'h3FF;

    always #2 clk = ~clk;
    // pins rest at their inactive levels until their own scenario
    pic_prioritized_interrupt_control DUT (
        .clk, .rst, .nonmaskPinN(nmiN), .extRiseInput(rise), .extFallInput(fall),
        .upperAnalogPins(an), .timerAMatch(ev[0]), .timerBMatch(ev[1]),
        .evcntMatchA(ev[4]), .evcntMatchB(ev[5]), .countInputFall(ev[6]),
        .conversionStored(ev[7]), .rxBufferFull(ev[8]), .txBufferEmpty(ev[9]),
        .evcntOverflow(ev[2]), .rxError(ev[3]), .supplyRise(ev[10]), .cmd, .ack,
        .skipResult, .globalEnableFf(ge), .regAddr(rAddr), .regWdata(rWd),
        .regWrite(rWr), .regRead(rRd), .regRdata(rDat));
    pic_core_model core (.clk, .ack, .lastVec, .busyLen, .orderOk);

    // ------------------------------------------------------------
    // model and helpers
    // ------------------------------------------------------------
    // expected vector; bit 10 of the flag word stands for the nonmaskable flag
    function automatic logic [15:0] model_vec(input int fl, input int mk, input logic en);
        if (fl[10]) return 16'h0004;
        if (en !== 1'h1) return 16'h0000;
        for (int g = 0; g < 5; g++) begin
            if ((((fl & ~mk) >> (2 * g)) & 3) != 0) return 16'(8 + 8 * g);
        end
        return 16'h0000;
    endfunction : model_vec
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic reg_io(input logic a, input logic wr, input logic [7:0] d);
        @(posedge clk);
        rAddr <= a;
        rWd   <= d;
        rWr   <= wr;
        rRd   <= ~wr;
        @(posedge clk);
        rWr <= 1'h0;
        rRd <= 1'h0;
        @(negedge clk);
    endtask : reg_io
    task automatic pulse(input int i, input logic [4:0] cfield);
        @(posedge clk);
        ev[i] <= (cfield == 5'h00);
        cmd.enableInstr  <= (cfield == 5'h01);
        cmd.stopMode     <= (cfield == 5'h02);
        cmd.disableInstr <= (cfield == 5'h03);
        cmd.maskWrite    <= (cfield == 5'h04);
        cmd.maskBit      <= 4'h9;
        cmd.maskValue    <= 1'h0;
        @(posedge clk);
        ev <= 11'h000;
        cmd.enableInstr  <= 1'h0;
        cmd.stopMode     <= 1'h0;
        cmd.disableInstr <= 1'h0;
        cmd.maskWrite    <= 1'h0;
        if (cfield == 5'h00) mFl[i] = 1;
        @(negedge clk);
    endtask : pulse
    task automatic skip(input logic [4:0] sel);
        @(posedge clk);
        cmd.skipTest <= 1'h1;
        cmd.skipSel  <= sel;
        @(posedge clk);
        cmd.skipTest <= 1'h0;
        @(negedge clk);
        v = skipResult;
        if (sel < 5'h0A) mFl[sel] = 0;
    endtask : skip
    // one acknowledge; the model flags are cleared as the pairing rule says
    task automatic do_ack(input logic trap);
        int pair;
        @(posedge clk);
        cmd.instrEnd          <= ~trap;
        cmd.softwareTrapInstr <= trap;
        @(posedge clk);
        cmd.instrEnd          <= 1'h0;
        cmd.softwareTrapInstr <= 1'h0;
        @(negedge clk);
        bsy = ack.busy;
        for (int i = 0; i < 20 && bsy === 1'h1 && ack.vectorValid !== 1'h1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        pair = (lastVec >= 16'h0008 && lastVec <= 16'h0028) ? 3 << (lastVec - 8) / 4 : 0;
        if (bsy === 1'h1 && lastVec == 16'h0004) mFl[10] = 0;
        if (bsy === 1'h1 && (mMk & pair) != 0) mFl &= ~(pair & ~mMk);
    endtask : do_ack

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hF833));
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        reg_io(1'h0, 1'h0, 8'h00);
        check(rDat, 8'hFF);
        reg_io(1'h1, 1'h0, 8'h00);
        check(rDat, 8'h03);
        check(ge, 1'h0);
        r = 8'($urandom);
        reg_io(1'h0, 1'h1, r);
        reg_io(1'h0, 1'h0, 8'h00);
        check(rDat, r);
        reg_io(1'h0, 1'h1, 8'h02);
        reg_io(1'h1, 1'h1, 8'h00);
        mMk = 'h002;
        $display("test reset and mask done");
        // timer A against serial receive, then a pending serial pair
        pulse(0, 5'h00);
        pulse(8, 5'h00);
        pulse(1, 5'h00);
        pulse(0, 5'h01);
        check(ge, 1'h1);
        do_ack(1'h0);
        check(lastVec, model_vec(mFl | 'h001, mMk, 1'h1));
        check(16'(busyLen), 16'h0010);
        check(ge, 1'h0);
        skip(5'h01);
        check(v, 1'h1);
        do_ack(1'h0);
        check(bsy, 1'h0);
        pulse(0, 5'h01);
        do_ack(1'h0);
        check(lastVec, 16'h0028);
        skip(5'h08);
        check(v, 1'h1);
        skip(5'h08);
        check(v, 1'h0);
        // masked source stays pending and wins once unmasked
        pulse(4, 5'h00);
        reg_io(1'h0, 1'h1, 8'h12);
        mMk = 'h012;
        pulse(0, 5'h01);
        do_ack(1'h0);
        check(bsy, 1'(model_vec(mFl, mMk, 1'h1) != 16'h0000));
        reg_io(1'h0, 1'h1, 8'h02);
        mMk = 'h002;
        do_ack(1'h0);
        check(lastVec, model_vec(mFl | 'h010, mMk, 1'h1));
        // nonmaskable while disabled, pin level test, software trap
        nmiN <= 1'h0;
        mFl[10] = 1;
        repeat (8) @(posedge clk);
        do_ack(1'h0);
        check(lastVec, 16'h0004);
        skip(5'h0A);
        check(v, 1'h0);
        @(posedge clk);
        nmiN <= 1'h1;
        repeat (4) @(posedge clk);
        skip(5'h0A);
        check(v, 1'h1);
        do_ack(1'h1);
        check(lastVec, 16'h0060);
        check(orderOk, 1'h1);
        // rising input: short pulse dropped, long pulse taken once
        rise <= 1'h1;
        repeat (8) @(posedge clk);
        rise <= 1'h0;
        repeat (40) @(posedge clk);
        skip(5'h02);
        check(v, 1'h0);
        rise <= 1'h1;
        repeat (40) @(posedge clk);
        skip(5'h02);
        check(v, 1'h1);
        repeat (40) @(posedge clk);
        skip(5'h02);
        check(v, 1'h0);
        pulse(2, 5'h00);
        skip(5'h0B);
        check(v, 1'h1);
        skip(5'h0B);
        check(v, 1'h0);
        // falling lanes, then enable, disable, stop and a per-bit mask write
        @(posedge clk);
        fall  <= 1'h0;
        an[0] <= 1'h0;
        repeat (40) @(posedge clk);
        skip(5'h03);
        check(v, 1'h1);
        skip(5'h0E);
        check(v, 1'h1);
        skip(5'h0E);
        check(v, 1'h0);
        pulse(0, 5'h01);
        check(ge, 1'h1);
        pulse(0, 5'h03);
        check(ge, 1'h0);
        pulse(0, 5'h02);
        pulse(0, 5'h04);
        reg_io(1'h1, 1'h0, 8'h00);
        check(rDat, 8'h01);
        $display("test acknowledge and flags done");
        stop_test();
    end
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #20000;
        err_count++;
        stop_test();
    end
endmodule : tb

`default_nettype wire
